// ---- design/cur_loop_pkg.sv ----
package cur_loop_pkg;

  // Frame layout.
  localparam int FRAME_BITS = 32;
  localparam int RW_BIT     = 31;
  localparam int CODE_HI    = 30;
  localparam int CODE_LO    = 27;
  localparam int CH_HI      = 25;
  localparam int CH_LO      = 24;

  // Register codes carried in the frame.
  localparam logic [3:0] CODE_THR = 4'h6;
  localparam logic [3:0] CODE_AZ  = 4'h7;
  localparam logic [3:0] CODE_FB  = 4'h8;

  // Field positions and widths.
  localparam int OPEN_W       = 6;
  localparam int THR_W        = 16;
  localparam int AZ_W         = 13;
  localparam int OFFSET_CAL_TRIGGER_BIT = 23;
  localparam int CAL_W        = 16;
  localparam int SUM_W        = 12;
  localparam int PER_W        = 12;
  localparam int PEAK_W       = 8;

  // Values after reset and after a read.
  localparam logic [5:0]  OPEN_RST = 6'h00;
  localparam logic [15:0] THR_RST  = 16'h0000;
  localparam logic [12:0] AZ_RST   = 13'h0000;
  localparam logic [11:0] SUM_RST  = 12'h000;
  localparam logic [11:0] PER_RST  = 12'h000;
  localparam logic [7:0]  MAX_RST  = 8'h00;
  localparam logic [7:0]  MIN_RST  = 8'hFF;
  localparam logic [7:0]  CNT_RST  = 8'h00;

  // One period step spans this many system clocks.
  localparam int          PERIOD_CLKS = 16;
  localparam logic [3:0]  PRE_LAST    = 4'(PERIOD_CLKS - 1);

endpackage : cur_loop_pkg

// ---- design/cur_loop_regs.sv ----
`timescale 1ns/1ps
module cur_loop_regs #(
  parameter int NUM_CH = 3  // Channels served, at most three.
) (
  // System clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Serial link pins.
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso,
  // Channel state from the controller core.
  input  wire logic [NUM_CH-1:0]    chan_operating,
  input  wire logic                 cal_mode,
  input  wire logic [NUM_CH-1:0]    feedback_format_select,
  input  wire logic [NUM_CH-1:0]    dither_on,
  input  wire logic [NUM_CH*16-1:0] int_thresh_in,
  input  wire logic [NUM_CH*16-1:0] cal_current_in,
  // Calibration results.
  input  wire logic [NUM_CH-1:0]    az_done,
  input  wire logic [NUM_CH*13-1:0] measured_offset_in,
  // Current measurements.
  input  wire logic [NUM_CH-1:0]    cycle_end,
  input  wire logic [NUM_CH*12-1:0] cycle_sum_in,
  input  wire logic [NUM_CH-1:0]    cur_valid,
  input  wire logic [NUM_CH*8-1:0]  cur_sample_in,
  input  wire logic [NUM_CH-1:0]    dither_end,
  // Controls to the core.
  output logic [NUM_CH*6-1:0]       open_limit,
  output logic [NUM_CH-1:0]         olw_enable,
  output logic [NUM_CH-1:0]         offset_cal_trigger
);

  // The two-bit channel field has room for four codes; at most three channels are served.
  if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 3.");
  end

  // Words exchanged with the link-clock end.
  logic [31:0] rx_word;     // Last whole frame, steady for a frame time.
  logic        rx_toggle;   // Flips once per received frame.
  logic [31:0] resp_q;      // Answer shifted out during the next frame.

  // Toggle synchroniser; only the second and third stages feed logic.
  logic        tgl_s1_q;
  logic        tgl_s2_q;
  logic        tgl_s3_q;

  // Frame decode.
  logic        frame_pulse; // One cycle per new frame.
  logic        rw;          // Write request.
  logic [3:0]  code;        // Register code.
  logic [1:0]  ch_w;        // Channel number.
  logic        ch_ok;       // Channel exists.
  logic [1:0]  ch_idx;      // Safe index for lookups.
  logic        is_thr;
  logic        is_az;
  logic        is_fb;

  // Per-channel register state.
  logic [5:0]  open_q   [NUM_CH];  // Open-load-on limit.
  logic [15:0] thr_q    [NUM_CH];  // Integrator threshold copy.
  logic [12:0] ofs_q    [NUM_CH];  // Measured offset.
  logic        olw_q    [NUM_CH];  // Detection enabled.
  logic        az_q     [NUM_CH];  // Calibration start pulse.
  logic        fb_rd    [NUM_CH];  // Feedback read strobe.

  // Feedback fields from each channel.
  logic [11:0] sum_w    [NUM_CH];
  logic [11:0] per_w    [NUM_CH];
  logic [7:0]  max_w    [NUM_CH];
  logic [7:0]  min_w    [NUM_CH];
  logic [7:0]  cnt_w    [NUM_CH];
  logic [15:0] cal_w    [NUM_CH];

  // Answer assembly.
  logic [23:0] thr_data;
  logic [23:0] az_data;
  logic [23:0] fb_data;
  logic [23:0] data_sel;
  logic [31:0] resp_d;

  // The serial shifter runs on the link clock; it only ever hands whole words across.
  serial_link u_link (
    .spi_sclk  (spi_sclk),
    .spi_cs_n  (spi_cs_n),
    .spi_mosi  (spi_mosi),
    .spi_miso  (spi_miso),
    .rst_n     (rst_n),
    .resp_word (resp_q),
    .rx_word   (rx_word),
    .rx_toggle (rx_toggle)
  );

  // Bring the frame toggle into the system domain.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= rx_toggle;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // A toggle change marks a frame; the word has settled long before it shows.
  assign frame_pulse = tgl_s2_q ^ tgl_s3_q;
  assign rw          = rx_word[cur_loop_pkg::RW_BIT];
  assign code        = rx_word[cur_loop_pkg::CODE_HI:cur_loop_pkg::CODE_LO];
  assign ch_w        = rx_word[cur_loop_pkg::CH_HI:cur_loop_pkg::CH_LO];
  assign ch_ok       = int'(ch_w) < NUM_CH;
  assign ch_idx      = ch_ok ? ch_w : 2'h0;
  assign is_thr      = code == cur_loop_pkg::CODE_THR;
  assign is_az       = code == cur_loop_pkg::CODE_AZ;
  assign is_fb       = code == cur_loop_pkg::CODE_FB;

  // Everything that repeats per channel.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic hit;      // This frame addresses channel i.
    logic wr_thr;   // Limit write.
    logic az_go;    // Calibration start request.

    assign hit    = frame_pulse && ch_ok && (ch_w == 2'(i));
    assign wr_thr = hit && rw && is_thr;
    // Only a one in the start bit does anything; a zero is a plain no-op.
    assign az_go  = hit && rw && is_az && rx_word[cur_loop_pkg::OFFSET_CAL_TRIGGER_BIT];
    // Any frame at the feedback code is a read, whatever its direction bit.
    assign fb_rd[i] = hit && is_fb;
    assign cal_w[i] = cal_current_in[i*16 +: 16];

    // Writable limit, the flag derived from it and the calibration start pulse.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        open_q[i] <= cur_loop_pkg::OPEN_RST;
        olw_q[i]  <= 1'b0;
        az_q[i]   <= 1'b0;
      end else begin
        if (wr_thr) begin
          open_q[i] <= rx_word[cur_loop_pkg::OPEN_W-1:0];
        end
        olw_q[i] <= open_q[i] != cur_loop_pkg::OPEN_RST;
        // Calibration is meant for a disabled channel; the host takes care of that.
        az_q[i]  <= az_go;
      end
    end

    // Read-only status copied from the core.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        thr_q[i] <= cur_loop_pkg::THR_RST;
        ofs_q[i] <= cur_loop_pkg::AZ_RST;
      end else begin
        thr_q[i] <= int_thresh_in[i*16 +: 16];
        if (az_done[i]) begin
          ofs_q[i] <= measured_offset_in[i*13 +: 13];
        end
      end
    end

    // Feedback capture; the read strobe clears every field except the period.
    feedback_channel u_fb (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .cycle_end  (cycle_end[i]),
      .cycle_sum  (cycle_sum_in[i*12 +: 12]),
      .cur_valid  (cur_valid[i]),
      .cur_sample (cur_sample_in[i*8 +: 8]),
      .dither_on  (dither_on[i]),
      .dither_end (dither_end[i]),
      .rd_clr     (fb_rd[i]),
      .sum_q      (sum_w[i]),
      .period_q   (per_w[i]),
      .max_q      (max_w[i]),
      .min_q      (min_w[i]),
      .count_q    (cnt_w[i])
    );

    // Outputs straight from the flops above.
    assign open_limit[i*6 +: 6]  = open_q[i];
    assign olw_enable[i]         = olw_q[i];
    assign offset_cal_trigger[i] = az_q[i];
  end

  // Threshold word: two zero bits, threshold, then limit.
  assign thr_data = {2'b00, thr_q[ch_idx], open_q[ch_idx]};
  // The start bit reads back as zero; it is an action, not a state.
  assign az_data  = {11'h000, ofs_q[ch_idx]};

  // Feedback layout follows the channel's operating bit first, then calibration mode, then the format bit.
  assign fb_data = !chan_operating[ch_idx] ? 24'h00_0000
                 : cal_mode ? {cal_w[ch_idx], 8'h00}
                 : !feedback_format_select[ch_idx]
                 ? {sum_w[ch_idx], per_w[ch_idx]}
                 : {max_w[ch_idx], min_w[ch_idx], cnt_w[ch_idx]};

  // Unknown codes and the missing channel answer with an empty data field.
  assign data_sel = !ch_ok ? 24'h00_0000
                  : is_thr ? thr_data
                  : is_az  ? az_data
                  : is_fb  ? fb_data
                  : 24'h00_0000;

  // Header echoes code and channel with the direction bit forced low.
  assign resp_d = {1'b0, code, 1'b0, ch_w, data_sel};

  // The answer is taken in the cycle of the read, before the clear lands.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= 32'h0000_0000;
    end else if (frame_pulse) begin
      resp_q <= resp_d;
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_RW_LOW: assert property (frame_pulse |=> !resp_q[31] && resp_q[30:27] == $past(code))
    else $error("Answer does not echo the frame with a low direction bit.");

  AST_BAD_CH: assert property (frame_pulse && ch_w == 2'h3 |=> resp_q[23:0] == 24'h00_0000)
    else $error("Missing channel returned data.");

  AST_THR_READ: assert property (frame_pulse && is_thr && ch_w == 2'h0
      |=> resp_q[21:6] == $past(thr_q[0]) && resp_q[23:22] == 2'b00)
    else $error("Threshold field does not show the controller value.");

  AST_LIMIT_WR: assert property (frame_pulse && rw && is_thr && ch_w == 2'h0
      |=> open_limit[5:0] == $past(rx_word[5:0]))
    else $error("Limit write not stored.");

  AST_OLW_OFF: assert property (frame_pulse && rw && is_thr && ch_w == 2'h0 && rx_word[5:0] == 6'h00
      |=> ##1 !olw_enable[0])
    else $error("Detection enabled with a zero limit.");

  AST_AZ_PULSE: assert property (frame_pulse && rw && is_az && ch_w == 2'h1 && rx_word[23]
      |=> offset_cal_trigger[1] ##1 !offset_cal_trigger[1])
    else $error("Calibration start not a single pulse.");

  AST_AZ_NOP: assert property (frame_pulse && is_az && !rx_word[23]
      |=> offset_cal_trigger == '0)
    else $error("Zero start bit began calibration.");

  AST_OFFSET: assert property (az_done[0] |=> ofs_q[0] == $past(measured_offset_in[12:0]))
    else $error("Calibration result not captured.");

  AST_FB_NOWRITE: assert property (frame_pulse && rw && is_fb
      |=> $stable(open_limit) && offset_cal_trigger == '0)
    else $error("Feedback write changed state.");

  AST_CAL_LAYOUT: assert property (frame_pulse && is_fb && ch_w == 2'h0 && chan_operating[0] && cal_mode
      |=> resp_q[23:8] == $past(cal_current_in[15:0]) && resp_q[7:0] == 8'h00)
    else $error("Calibration current layout wrong.");

  AST_FB_IDLE: assert property (frame_pulse && is_fb && ch_w == 2'h0 && !chan_operating[0]
      |=> resp_q[23:0] == 24'h00_0000)
    else $error("Idle channel returned feedback.");

  AST_SUM_CLR: assert property (fb_rd[0] && !cycle_end[0] |=> sum_w[0] == 12'h000)
    else $error("Average field not cleared by a read.");

  AST_MIN_SET: assert property (fb_rd[0] && dither_on[0] && !dither_end[0]
      |=> min_w[0] == 8'hFF && cnt_w[0] == 8'h00 && max_w[0] == 8'h00)
    else $error("Extremes not reset by a read.");

endmodule : cur_loop_regs

// ---- design/feedback_channel.sv ----
`timescale 1ns/1ps
// Current and period feedback capture for one channel.
module feedback_channel (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Measurement events.
  input  wire logic       cycle_end,
  input  wire logic [11:0] cycle_sum,
  input  wire logic       cur_valid,
  input  wire logic [7:0] cur_sample,
  input  wire logic       dither_on,
  input  wire logic       dither_end,
  input  wire logic       rd_clr,
  // Captured fields.
  output logic [11:0]     sum_q,
  output logic [11:0]     period_q,
  output logic [7:0]      max_q,
  output logic [7:0]      min_q,
  output logic [7:0]      count_q
);

  logic [3:0]  pre_q;      // Divides the clock by the period step.
  logic [11:0] per_cnt_q;  // Steps since the last cycle end.
  logic [7:0]  run_max_q;  // Peak within the running dither cycle.
  logic [7:0]  run_min_q;  // Valley within the running dither cycle.
  logic [7:0]  run_cnt_q;  // Cycles within the running dither cycle.
  logic [11:0] per_inc;
  logic [7:0]  smax, smin, scnt, live_max, live_min;
  logic [7:0]  max_d, min_d, cnt_d;

  // Counters saturate rather than wrap, so a stuck cycle reads as longest.
  assign per_inc  = (per_cnt_q == 12'hFFF) ? per_cnt_q : per_cnt_q + 12'h001;
  assign smax     = (cur_valid && cur_sample > run_max_q) ? cur_sample : run_max_q;
  assign smin     = (cur_valid && cur_sample < run_min_q) ? cur_sample : run_min_q;
  assign scnt     = (cycle_end && run_cnt_q != 8'hFF) ? run_cnt_q + 8'h01 : run_cnt_q;
  // Without dither the extremes run since the last read; a new sample beats the clear.
  assign live_max = rd_clr ? (cur_valid ? cur_sample : cur_loop_pkg::MAX_RST)
                  : ((cur_valid && cur_sample > max_q) ? cur_sample : max_q);
  assign live_min = rd_clr ? (cur_valid ? cur_sample : cur_loop_pkg::MIN_RST)
                  : ((cur_valid && cur_sample < min_q) ? cur_sample : min_q);
  // With dither a cycle end publishes; a read clears only when nothing is published.
  assign max_d = !dither_on ? live_max : dither_end ? smax : rd_clr ? cur_loop_pkg::MAX_RST : max_q;
  assign min_d = !dither_on ? live_min : dither_end ? smin : rd_clr ? cur_loop_pkg::MIN_RST : min_q;
  assign cnt_d = !dither_on ? cur_loop_pkg::CNT_RST : dither_end ? scnt
               : rd_clr ? cur_loop_pkg::CNT_RST : count_q;

  // Period measurement and the sum of the last switching cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q     <= 4'h0;
      per_cnt_q <= 12'h000;
      period_q  <= cur_loop_pkg::PER_RST;
      sum_q     <= cur_loop_pkg::SUM_RST;
    end else if (cycle_end) begin
      pre_q     <= 4'h0;
      per_cnt_q <= 12'h000;
      // The step that ends on this very edge still counts, so 48 clocks read as three steps.
      period_q  <= (pre_q == cur_loop_pkg::PRE_LAST) ? per_inc : per_cnt_q;
      sum_q     <= cycle_sum;
    end else begin
      pre_q     <= pre_q + 4'h1;
      per_cnt_q <= (pre_q == cur_loop_pkg::PRE_LAST) ? per_inc : per_cnt_q;
      sum_q     <= rd_clr ? cur_loop_pkg::SUM_RST : sum_q;
    end
  end

  // Extremes and cycle count.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_max_q <= cur_loop_pkg::MAX_RST;
      run_min_q <= cur_loop_pkg::MIN_RST;
      run_cnt_q <= cur_loop_pkg::CNT_RST;
      max_q     <= cur_loop_pkg::MAX_RST;
      min_q     <= cur_loop_pkg::MIN_RST;
      count_q   <= cur_loop_pkg::CNT_RST;
    end else begin
      run_max_q <= (dither_end || !dither_on) ? cur_loop_pkg::MAX_RST : smax;
      run_min_q <= (dither_end || !dither_on) ? cur_loop_pkg::MIN_RST : smin;
      run_cnt_q <= (dither_end || !dither_on) ? cur_loop_pkg::CNT_RST : scnt;
      max_q     <= max_d;
      min_q     <= min_d;
      count_q   <= cnt_d;
    end
  end

endmodule : feedback_channel

// ---- design/serial_link.sv ----
`timescale 1ns/1ps
// Link-clock end of the serial port: shifts frames in and answers out.
module serial_link (
  // Link pins.
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  // System reset.
  input  wire logic        rst_n,
  // Words to and from the system clock domain.
  input  wire logic [31:0] resp_word,
  output logic [31:0]      rx_word,
  output logic             rx_toggle
);

  logic [4:0]  bit_cnt_q;  // Rising edges seen in this frame.
  logic [30:0] shift_q;    // Bits received so far.
  logic        link_clr;   // Frame idle or system in reset.

  assign link_clr = spi_cs_n | ~rst_n;

  // The counter restarts whenever select is released, so a cut frame is dropped.
  always_ff @(posedge spi_sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 31'h0000_0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q   <= {shift_q[29:0], spi_mosi};
    end
  end

  // The whole word and a toggle cross on the last bit; the word stays put a frame long.
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word   <= 32'h0000_0000;
      rx_toggle <= 1'b0;
    end else if (bit_cnt_q == 5'(cur_loop_pkg::FRAME_BITS - 1)) begin
      rx_word   <= {shift_q, spi_mosi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // Answer bits change on falling edges; bit 31 is always zero, so idle shows it.
  always_ff @(negedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso <= 1'b0;
    end else begin
      spi_miso <= resp_word[~bit_cnt_q];
    end
  end

endmodule : serial_link

// ---- verif/current_loop_status_regs_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the serial status registers.
module current_loop_status_regs_tb;
  logic        mclk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, cal_mode;
  logic [2:0]  chan_operating, fmt_sel, dither_on, az_done, cycle_end, cur_valid, dither_end, olw_enable, trig;
  logic [47:0] thresh_in, cal_in;  // Per-channel 16-bit words.
  logic [38:0] offset_in;          // Calibration results.
  logic [35:0] sum_in;             // Cycle sums.
  logic [23:0] sample_in;          // Current samples.
  logic [17:0] open_limit;         // Open-load limits.
  logic [7:0]  trig_cnt;           // Triggers weighted 1, 2, 4 by channel.
  logic [31:0] got, row_tx [8], row_exp [8];
  int          failures, n_checks;

  cur_loop_regs u_cur_loop_regs (
    .mclk(mclk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .chan_operating(chan_operating), .cal_mode(cal_mode),
    .feedback_format_select(fmt_sel), .dither_on(dither_on), .int_thresh_in(thresh_in),
    .cal_current_in(cal_in), .az_done(az_done), .measured_offset_in(offset_in), .cycle_end(cycle_end),
    .cycle_sum_in(sum_in), .cur_valid(cur_valid), .cur_sample_in(sample_in), .dither_end(dither_end),
    .open_limit(open_limit), .olw_enable(olw_enable), .offset_cal_trigger(trig));

  spi_host_model u_spi_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  // Clock at 250 MHz.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Trigger pulses are tallied, so a stuck or doubled pulse shows.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trig_cnt <= 8'h00;
    else trig_cnt <= trig_cnt + {5'h00, trig};
  end

  // Frame word builder: direction, code, channel and data.
  function automatic logic [31:0] frm(input logic rw, input logic [3:0] c, input logic [1:0] ch, input logic [23:0] d);
    return {rw, c, 1'b0, ch, d};
  endfunction : frm

  // Compares a value seen with the value expected.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // The answer comes one frame late, so a blank read follows each frame.
  task automatic access(input logic [31:0] tx, input int gap);
    logic [31:0] skip;
    u_spi_host_model.xfer(tx, gap, skip);
    u_spi_host_model.xfer(32'h00000000, gap, got);
  endtask : access

  // One-cycle event pulses; the sample goes to channel one.
  task automatic ev(input logic [2:0] ce, input logic [2:0] cv, input logic [2:0] de, input logic [7:0] s);
    @(posedge mclk);
    cycle_end  <= ce;
    cur_valid  <= cv;
    dither_end <= de;
    sample_in  <= {8'h00, s, 8'h00};
    @(posedge mclk);
    cycle_end  <= 3'h0;
    cur_valid  <= 3'h0;
    dither_end <= 3'h0;
  endtask : ev

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // A hang counts as a mismatch.
  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    {rst_n, cal_mode, fmt_sel, dither_on, az_done, cycle_end, cur_valid, sample_in, dither_end} = '0;
    chan_operating = 3'h3;  // Channel two stays off for calibration.
    thresh_in = {16'h0F0F, 16'hABCD, 16'h1234};
    cal_in    = {32'h00000000, 16'hBEEF};
    offset_in = {13'h1ABC, 26'h0000000};
    sum_in    = {12'h333, 12'h222, 12'h5A5};
    failures  = 0;
    n_checks  = 0;
    // Rows: frame sent, answer expected.
    row_tx[0] = frm(1'b1, 4'h6, 2'h1, 24'h3FFFEA); row_exp[0] = frm(1'b0, 4'h6, 2'h1, 24'h2AF340);
    row_tx[1] = frm(1'b0, 4'h6, 2'h1, 24'h000000); row_exp[1] = frm(1'b0, 4'h6, 2'h1, 24'h2AF36A);
    row_tx[2] = frm(1'b0, 4'h6, 2'h3, 24'h000000); row_exp[2] = frm(1'b0, 4'h6, 2'h3, 24'h000000);
    row_tx[3] = frm(1'b1, 4'h8, 2'h0, 24'hFFFFFF); row_exp[3] = frm(1'b0, 4'h8, 2'h0, 24'h5A5003);
    row_tx[4] = frm(1'b0, 4'h8, 2'h0, 24'h000000); row_exp[4] = frm(1'b0, 4'h8, 2'h0, 24'h000003);
    row_tx[5] = frm(1'b0, 4'h8, 2'h2, 24'h000000); row_exp[5] = frm(1'b0, 4'h8, 2'h2, 24'h000000);
    row_tx[6] = frm(1'b1, 4'hF, 2'h0, 24'hFFFFFF); row_exp[6] = frm(1'b0, 4'hF, 2'h0, 24'h000000);
    row_tx[7] = frm(1'b1, 4'h6, 2'h0, 24'h000000); row_exp[7] = frm(1'b0, 4'h6, 2'h0, 24'h048D00);
    repeat (8) @(posedge mclk);
    check("limits_reset", {11'h000, olw_enable, open_limit}, 32'h00000000);
    rst_n <= 1'b1;
    // Two cycle ends 48 clocks apart give a period of three steps.
    ev(3'h7, 3'h0, 3'h0, 8'h00);
    repeat (46) @(posedge mclk);
    ev(3'h7, 3'h0, 3'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      access(row_tx[i], 25);
      check("row", got, row_exp[i]);
    end
    check("limits", {11'h000, olw_enable, open_limit}, 32'h00080A80);
    // Peak, minimum and count with dither off, then after a read.
    @(posedge mclk);
    fmt_sel <= 3'h2;
    ev(3'h0, 3'h2, 3'h0, 8'h40);
    ev(3'h0, 3'h2, 3'h0, 8'h90);
    ev(3'h0, 3'h2, 3'h0, 8'h20);
    access(frm(1'b0, 4'h8, 2'h1, 24'h000000), 25);
    check("fb_fmt1", got, frm(1'b0, 4'h8, 2'h1, 24'h902000));
    access(frm(1'b0, 4'h8, 2'h1, 24'h000000), 200);
    check("fb_clear", got, frm(1'b0, 4'h8, 2'h1, 24'h00FF00));
    // One dither cycle holding one sample and two switching cycles.
    @(posedge mclk);
    dither_on <= 3'h2;
    ev(3'h0, 3'h2, 3'h0, 8'h70);
    ev(3'h2, 3'h0, 3'h0, 8'h00);
    ev(3'h2, 3'h0, 3'h0, 8'h00);
    ev(3'h0, 3'h0, 3'h2, 8'h00);
    access(frm(1'b0, 4'h8, 2'h1, 24'h000000), 25);
    check("fb_dither", got, frm(1'b0, 4'h8, 2'h1, 24'h707002));
    @(posedge mclk);
    cal_mode <= 1'b1;
    access(frm(1'b0, 4'h8, 2'h0, 24'h000000), 25);
    check("fb_cal", got, frm(1'b0, 4'h8, 2'h0, 24'hBEEF00));
    cal_mode <= 1'b0;
    // Calibration on the disabled channel two: a zero start does nothing.
    access(frm(1'b1, 4'h7, 2'h2, 24'h000000), 25);
    check("trig_zero", {24'h000000, trig_cnt}, 32'h00000000);
    access(frm(1'b1, 4'h7, 2'h2, 24'h800000), 25);
    check("trig_one", {24'h000000, trig_cnt}, 32'h00000004);
    @(posedge mclk);
    az_done <= 3'h4;
    @(posedge mclk);
    az_done <= 3'h0;
    access(frm(1'b0, 4'h7, 2'h2, 24'h000000), 25);
    check("offset", got, frm(1'b0, 4'h7, 2'h2, 24'h001ABC));
    // All channels off: calibration of channel one is allowed, feedback of channel zero reads zero.
    @(posedge mclk);
    chan_operating <= 3'h0;
    access(frm(1'b1, 4'h7, 2'h1, 24'h800000), 25);
    check("trig_ch1", {24'h000000, trig_cnt}, 32'h00000006);
    access(frm(1'b0, 4'h8, 2'h0, 24'h000000), 25);
    check("fb_off", got, frm(1'b0, 4'h8, 2'h0, 24'h000000));
    results();
  end
endmodule : current_loop_status_regs_tb

// ---- verif/spi_host_model.sv ----
`timescale 1ns/1ps
// Host end of the serial link: a frame master with a 30 ns link clock.
module spi_host_model (
  // Link pins.
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // The link idles with the clock low and the frame deselected.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One frame, bit 31 first; the gap makes the host prompt or slow.
  task automatic xfer(input logic [31:0] tx, input int gap, output logic [31:0] rx);
    #3;
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      #15;
      spi_sclk = 1'b1;
      rx[i]    = spi_miso;
      #15;
      spi_sclk = 1'b0;
    end
    #(gap);
    spi_cs_n = 1'b1;
    // The released data line flips, so a stale bit never looks valid.
    spi_mosi = ~spi_mosi;
    #(gap);
  endtask : xfer
endmodule : spi_host_model
